/* File: common/clock_cfg_params.svh */
// constants of the clock output configuration bank: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and design files
`ifndef CLOCK_CFG_PARAMS_SVH
`define CLOCK_CFG_PARAMS_SVH

// ---------------------------------------------------------------
// serial write framing
// ---------------------------------------------------------------
`define DEV_WRITE_ADDR 8'hD2
`define DUMMY_BYTES 3'h2
`define CFG_BYTES 3'h6
`define BITS_PER_BYTE 4'h8

// ---------------------------------------------------------------
// configuration byte offsets
// ---------------------------------------------------------------
`define FUNCTION_FREQUENCY_SELECT 3'h0
`define FAST_AND_USB_CLOCK_ENABLE 3'h1
`define BUS_CLOCK_ENABLE 3'h2
`define MEMORY_CLOCK_ENABLE_LOW 3'h3
`define MEMORY_CLOCK_ENABLE_HIGH 3'h4
`define PERIPHERAL_CLOCK_ENABLE 3'h5

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define FUNC_MODE_LSB 0
`define FUNC_USB_48_BIT 2
`define FUNC_WRITE_MASK 8'h07
`define FUNC_RESET 8'h00
`define ENABLE_RESET 8'hFF
`define MODE_TRISTATE 2'h3
`define MODE_SPREAD 2'h2
`define EN_AUX_BIT 7
`define EN_USB_BIT 6
`define EN_FAST_A_BIT 0
`define EN_FAST_B_BIT 2
`define EN_FREE_BUS_BIT 6
`define EN_REF_BIT 0

// ---------------------------------------------------------------
// clock output slots
// ---------------------------------------------------------------
`define NUM_CLOCK_OUTPUTS 13
`define SLOT_FAST_A 0
`define SLOT_FAST_B 1
`define SLOT_MEM_A 2
`define SLOT_BUS_0 6
`define SLOT_FREE_BUS 9
`define SLOT_AUX 10
`define SLOT_USB 11
`define SLOT_REF 12

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLOCK_FREQ_KHZ 20000
`define STRAP_TIME_MS 10
`define STRAP_CYCLES (`STRAP_TIME_MS * `CLOCK_FREQ_KHZ)

`endif

/* File: common/clock_cfg_pkg.sv */
// types shared by the clock output configuration bank
// assumes the params header sits next to it on the include path
`include "clock_cfg_params.svh"

package clock_cfg_pkg;

	// ---------------------------------------------------------------
	// serial slave states, gray along the write path
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SER_IDLE = 3'h0,
		SER_ADDR = 3'h1,
		SER_ADDR_ACK = 3'h3,
		SER_DATA = 3'h2,
		SER_DATA_ACK = 3'h6
	} ser_state_t;

	// three-level strap reading
	typedef enum logic [1:0] {
		LEVEL_ZERO = 2'h0,
		LEVEL_MID = 2'h1,
		LEVEL_ONE = 2'h3
	} level3_t;

endpackage

/* File: core/pin_sync.sv */
// two flip-flop synchroniser for a group of pin levels
// assumes each bit is a slow level, not a bus of related values
`timescale 1ns/1ns

module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] meta_q;

	// an empty group has nothing to carry
	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pin group must hold at least one bit");
		end
	endgenerate

	// first stage is read only by the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			level <= '0;
		end else begin
			meta_q <= pin;
			level <= meta_q;
		end
	end
endmodule

/* File: core/clock_gate.sv */
// runt-free gate for one clock output slot
// assumes phase is a divider level on the same clock as this logic
`timescale 1ns/1ns

module clock_gate (
	input wire logic clock,
	input wire logic rst,
	input wire logic phase,
	input wire logic enable,
	output logic gated
);
	logic en_q;

	// enable only moves while the phase is low, so no cut pulse
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			en_q <= 1'b0;
			gated <= 1'b0;
		end else begin
			if (!phase) begin
				en_q <= enable;
			end
			gated <= phase & en_q;
		end
	end
endmodule

/* File: core/clock_output_config_bank.sv */
// write-only configuration bank of a multi-output clock synthesizer
// assumes a serial bus master on scl/sda pins, pads with pulls and a pll phase per output
`timescale 1ns/1ns
`include "clock_cfg_params.svh"

module clock_output_config_bank
	import clock_cfg_pkg::*;
#(
	parameter int unsigned STRAP_CYCLES = `STRAP_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic sda_out,
	output logic sda_oe,
	input wire logic host_pair_disable_strap,
	input wire logic usb_freq_strap,
	input wire logic low_emi_strap,
	input wire logic host_speed_strap,
	input wire logic host_stop_strap,
	input wire logic bus_stop_strap,
	input wire logic cpu_slow_select_strap,
	input wire logic free_bus_select_above_low,
	input wire logic free_bus_select_above_high,
	input wire logic aux_freq_above_low,
	input wire logic aux_freq_above_high,
	input wire logic out_tristate_above_low,
	input wire logic out_tristate_above_high,
	input wire logic [`NUM_CLOCK_OUTPUTS-1:0] clk_phase,
	output logic [`NUM_CLOCK_OUTPUTS-1:0] clk_out,
	output logic [`NUM_CLOCK_OUTPUTS-1:0] clk_oe,
	output logic strap_bias_en,
	output logic straps_done,
	output logic [6:0] strap_levels,
	output clock_cfg_pkg::level3_t free_bus_select_level,
	output clock_cfg_pkg::level3_t aux_freq_level,
	output clock_cfg_pkg::level3_t out_tristate_level,
	output logic usb_48,
	output logic spread_host,
	output logic spread_bus
);
	import clock_cfg_pkg::*;

	localparam int unsigned TW = $clog2(STRAP_CYCLES + 1);

	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	generate
		if (STRAP_CYCLES < 3) begin : g_bad_strap
			$error("strap window must outlast the two-stage pin sync");
		end
	endgenerate

	// ---------------------------------------------------------------
	// state of the block, less the pin synchroniser and the output gates
	// ---------------------------------------------------------------
	typedef struct packed {
		logic scl_prev;
		logic sda_prev;
		ser_state_t st;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [2:0] byte_idx;
		logic sda_oe;
		logic sda_out;
		logic [5:0][7:0] cfg;
		logic byte0_written;
		logic [TW-1:0] timer;
		logic straps_done;
		logic strap_bias_en;
		logic [6:0] strap2;
		level3_t free_bus_sel;
		level3_t aux_freq_sel;
		level3_t out_tristate_sel;
		logic [`NUM_CLOCK_OUTPUTS-1:0] clk_en;
		logic [`NUM_CLOCK_OUTPUTS-1:0] clk_oe;
		logic usb_48;
		logic spread_host;
		logic spread_bus;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// window comparators give zero, mid or one; a crossed pair reads mid
	function automatic level3_t decode3(input logic above_low, input logic above_high);
		if (above_low && above_high) begin
			decode3 = LEVEL_ONE;
		end else if (!above_low && !above_high) begin
			decode3 = LEVEL_ZERO;
		end else begin
			decode3 = LEVEL_MID;
		end
	endfunction

	// map the stored bytes onto the output slots
	function automatic logic [`NUM_CLOCK_OUTPUTS-1:0] slot_enables(input logic [5:0][7:0] cfg);
		logic [`NUM_CLOCK_OUTPUTS-1:0] en;
		en = '0;
		// one bit of each equal pair is used; the master keeps them alike
		en[`SLOT_FAST_A] = cfg[`FAST_AND_USB_CLOCK_ENABLE][`EN_FAST_A_BIT];
		en[`SLOT_FAST_B] = cfg[`FAST_AND_USB_CLOCK_ENABLE][`EN_FAST_B_BIT];
		en[`SLOT_AUX] = cfg[`FAST_AND_USB_CLOCK_ENABLE][`EN_AUX_BIT];
		en[`SLOT_USB] = cfg[`FAST_AND_USB_CLOCK_ENABLE][`EN_USB_BIT];
		en[`SLOT_MEM_A+3:`SLOT_MEM_A] = cfg[`MEMORY_CLOCK_ENABLE_LOW][3:0];
		en[`SLOT_BUS_0+2:`SLOT_BUS_0] = cfg[`BUS_CLOCK_ENABLE][2:0];
		en[`SLOT_FREE_BUS] = cfg[`BUS_CLOCK_ENABLE][`EN_FREE_BUS_BIT];
		en[`SLOT_REF] = cfg[`PERIPHERAL_CLOCK_ENABLE][`EN_REF_BIT];
		// the fifth byte is kept but feeds no slot
		slot_enables = en;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	logic [6:0] strap2_s;
	logic [5:0] strap3_s;

	pin_sync #(
		.WIDTH(15)
	) u_pin_sync (
		.clock(clock),
		.rst(rst),
		.pin({scl_pin, sda_pin,
			host_pair_disable_strap, usb_freq_strap, low_emi_strap, host_speed_strap,
			host_stop_strap, bus_stop_strap, cpu_slow_select_strap,
			free_bus_select_above_low, free_bus_select_above_high,
			aux_freq_above_low, aux_freq_above_high,
			out_tristate_above_low, out_tristate_above_high}),
		.level({scl_s, sda_s, strap2_s, strap3_s})
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic ser_start;
	logic ser_stop;
	logic scl_rise;
	logic scl_fall;
	logic power_down;
	logic [2:0] slot;
	logic [1:0] mode;

	always_comb begin
		s_d = s_q;
		slot = s_q.byte_idx - `DUMMY_BYTES;
		ser_start = scl_s & s_q.sda_prev & ~sda_s;
		ser_stop = scl_s & ~s_q.sda_prev & sda_s;
		scl_rise = scl_s & ~s_q.scl_prev;
		scl_fall = ~scl_s & s_q.scl_prev;
		// host stop strap pin low means power-down; it stays a live input
		power_down = s_q.straps_done & ~strap2_s[2];
		s_d.scl_prev = scl_s;
		s_d.sda_prev = sda_s;
		s_d.sda_out = 1'b0;

		// strap window: pulls on, sample every cycle, freeze at the end
		if (!s_q.straps_done) begin
			s_d.strap_bias_en = 1'b1;
			s_d.strap2 = strap2_s;
			s_d.free_bus_sel = decode3(strap3_s[5], strap3_s[4]);
			s_d.aux_freq_sel = decode3(strap3_s[3], strap3_s[2]);
			s_d.out_tristate_sel = decode3(strap3_s[1], strap3_s[0]);
			if (s_q.timer == TW'(STRAP_CYCLES - 1)) begin
				s_d.straps_done = 1'b1;
				s_d.strap_bias_en = 1'b0;
				// usb strap seeds the frequency unless software already chose
				if (!s_q.byte0_written) begin
					s_d.cfg[`FUNCTION_FREQUENCY_SELECT][`FUNC_USB_48_BIT] = strap2_s[5];
				end
			end else begin
				s_d.timer = s_q.timer + 1'b1;
			end
		end

		// serial slave, write only
		case (s_q.st)
			SER_IDLE: begin
				s_d.sda_oe = 1'b0;
			end
			SER_ADDR: begin
				if (scl_rise) begin
					s_d.shift = {s_q.shift[6:0], sda_s};
					s_d.bit_cnt = s_q.bit_cnt + 1'b1;
				end else if (scl_fall && s_q.bit_cnt == `BITS_PER_BYTE) begin
					// a read address is left unanswered: nothing to read back
					if (s_q.shift == `DEV_WRITE_ADDR) begin
						s_d.sda_oe = 1'b1;
						s_d.st = SER_ADDR_ACK;
					end else begin
						s_d.st = SER_IDLE;
					end
				end
			end
			SER_ADDR_ACK: begin
				if (scl_fall) begin
					s_d.sda_oe = 1'b0;
					s_d.bit_cnt = '0;
					s_d.byte_idx = '0;
					s_d.st = SER_DATA;
				end
			end
			SER_DATA: begin
				if (scl_rise) begin
					s_d.shift = {s_q.shift[6:0], sda_s};
					s_d.bit_cnt = s_q.bit_cnt + 1'b1;
				end else if (scl_fall && s_q.bit_cnt == `BITS_PER_BYTE) begin
					// command and count bytes are acknowledged and dropped
					if (s_q.byte_idx < `DUMMY_BYTES) begin
						s_d.sda_oe = 1'b1;
						s_d.st = SER_DATA_ACK;
					end else if (slot < `CFG_BYTES) begin
						// a byte lands only once all eight bits are in
						if (slot == `FUNCTION_FREQUENCY_SELECT) begin
							s_d.cfg[slot] = s_q.shift & `FUNC_WRITE_MASK;
							s_d.byte0_written = 1'b1;
						end else begin
							s_d.cfg[slot] = s_q.shift;
						end
						s_d.sda_oe = 1'b1;
						s_d.st = SER_DATA_ACK;
					end else begin
						// past the sixth byte: refuse with no acknowledge
						s_d.st = SER_IDLE;
					end
				end
			end
			SER_DATA_ACK: begin
				if (scl_fall) begin
					s_d.sda_oe = 1'b0;
					s_d.bit_cnt = '0;
					s_d.byte_idx = s_q.byte_idx + 1'b1;
					// the byte index would wrap after the sixth byte, so stop taking
					s_d.st = (slot == `CFG_BYTES - 3'h1) ? SER_IDLE : SER_DATA;
				end
			end
			default: begin
				s_d.st = SER_IDLE;
				s_d.sda_oe = 1'b0;
			end
		endcase

		// start restarts the frame, stop ends loading
		if (ser_start) begin
			s_d.st = SER_ADDR;
			s_d.bit_cnt = '0;
			s_d.sda_oe = 1'b0;
		end else if (ser_stop) begin
			s_d.st = SER_IDLE;
			s_d.sda_oe = 1'b0;
		end

		// power-down floats the serial pins, stored bytes untouched
		if (power_down) begin
			s_d.st = SER_IDLE;
			s_d.sda_oe = 1'b0;
		end

		// output modes follow the stored first byte
		mode = s_d.cfg[`FUNCTION_FREQUENCY_SELECT][`FUNC_MODE_LSB+1:`FUNC_MODE_LSB];
		s_d.usb_48 = s_d.cfg[`FUNCTION_FREQUENCY_SELECT][`FUNC_USB_48_BIT];
		// 01 is plain normal operation, no test mode behind it
		s_d.spread_host = (mode == `MODE_SPREAD);
		s_d.spread_bus = (mode == `MODE_SPREAD);
		// clocks only start once the strap window has closed
		s_d.clk_en = s_d.straps_done ? slot_enables(s_d.cfg) : '0;
		// a disabled slot still drives low; only tristate mode and the open strap window float
		if (!s_d.straps_done || mode == `MODE_TRISTATE) begin
			s_d.clk_oe = '0;
		end else begin
			s_d.clk_oe = '1;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.scl_prev <= 1'b1;
			s_q.sda_prev <= 1'b1;
			s_q.st <= SER_IDLE;
			s_q.cfg[`FUNCTION_FREQUENCY_SELECT] <= `FUNC_RESET;
			s_q.cfg[`FAST_AND_USB_CLOCK_ENABLE] <= `ENABLE_RESET;
			s_q.cfg[`BUS_CLOCK_ENABLE] <= `ENABLE_RESET;
			s_q.cfg[`MEMORY_CLOCK_ENABLE_LOW] <= `ENABLE_RESET;
			s_q.cfg[`MEMORY_CLOCK_ENABLE_HIGH] <= `ENABLE_RESET;
			s_q.cfg[`PERIPHERAL_CLOCK_ENABLE] <= `ENABLE_RESET;
			s_q.strap_bias_en <= 1'b1;
			s_q.free_bus_sel <= LEVEL_MID;
			s_q.aux_freq_sel <= LEVEL_MID;
			s_q.out_tristate_sel <= LEVEL_MID;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// runt-free output gates
	// ---------------------------------------------------------------
	generate
		for (genvar i = 0; i < `NUM_CLOCK_OUTPUTS; i++) begin : g_gate
			clock_gate u_gate (
				.clock(clock),
				.rst(rst),
				.phase(clk_phase[i]),
				.enable(s_q.clk_en[i]),
				.gated(clk_out[i])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// outputs, all from the state register
	// ---------------------------------------------------------------
	assign sda_out = s_q.sda_out;
	assign sda_oe = s_q.sda_oe;
	assign clk_oe = s_q.clk_oe;
	assign strap_bias_en = s_q.strap_bias_en;
	assign straps_done = s_q.straps_done;
	assign strap_levels = s_q.strap2;
	assign free_bus_select_level = s_q.free_bus_sel;
	assign aux_freq_level = s_q.aux_freq_sel;
	assign out_tristate_level = s_q.out_tristate_sel;
	assign usb_48 = s_q.usb_48;
	assign spread_host = s_q.spread_host;
	assign spread_bus = s_q.spread_bus;
endmodule

/* File: verif/clock_cfg_bank_properties.sv */
// port assertions for the clock output configuration bank
// assumes a bind onto the bank top with its strap window length handed on
`timescale 1ns/1ns
`include "clock_cfg_params.svh"

module clock_cfg_bank_properties
	import clock_cfg_pkg::*;
#(
	parameter int unsigned STRAP_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [`NUM_CLOCK_OUTPUTS-1:0] clk_phase,
	input wire logic [`NUM_CLOCK_OUTPUTS-1:0] clk_out,
	input wire logic [`NUM_CLOCK_OUTPUTS-1:0] clk_oe,
	input wire logic strap_bias_en,
	input wire logic straps_done,
	input wire logic [6:0] strap_levels,
	input wire logic spread_host,
	input wire logic spread_bus
);
	// age since reset release, saturating so a long run never wraps
	logic [31:0] age_q;
	logic [31:0] age_d;
	always_comb begin
		age_d = (age_q == 32'hFFFFFFFF) ? age_q : age_q + 32'h1;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			age_q <= 32'h0;
		end else begin
			age_q <= age_d;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_sda_pull_only: assert property (sda_out == 1'b0)
		else $error("serial data driven high");
	a_bias_in_window: assert property (strap_bias_en == !straps_done)
		else $error("strap bias out of step with window");
	a_window_length: assert property ($rose(straps_done) |->
		age_q >= STRAP_CYCLES - 1 && age_q <= STRAP_CYCLES + 1)
		else $error("strap window length wrong");
	a_window_bound: assert property (!straps_done |-> age_q <= STRAP_CYCLES + 1)
		else $error("strap window overran");
	a_done_holds: assert property (straps_done |=> straps_done)
		else $error("strap window reopened");
	a_no_drive_window: assert property (!straps_done |-> clk_oe == '0)
		else $error("clock pad driven while straps sampled");
	a_levels_frozen: assert property (straps_done && $past(straps_done) |->
		$stable(strap_levels))
		else $error("strap levels moved after window");
	a_spread_pair: assert property (spread_host == spread_bus)
		else $error("spread differs between host and bus");
	a_oe_all_or_none: assert property (clk_oe == '0 || clk_oe == '1)
		else $error("clock pads partly floated");
	a_out_needs_phase: assert property ((clk_out & ~$past(clk_phase)) == '0)
		else $error("clock output high without phase");
	c_window_done: cover property ($rose(straps_done));
	c_ack: cover property ($rose(sda_oe));
	c_spread: cover property (spread_host);
	c_tristate: cover property (straps_done && clk_oe == '0);
endmodule

/* File: verif/i2c_master_model.sv */
// serial bus master model writing configuration frames
// assumes the bench resolves the sda wire from sda_low and the device drive
`timescale 1ns/1ns

module i2c_master_model #(
	parameter int unsigned QUARTER = 4
) (
	input wire logic clock,
	input wire logic sda_wire,
	output logic scl_level,
	output logic sda_low
);
	// released bus at time zero, both lines pulled up
	initial begin
		scl_level = 1'b1;
		sda_low = 1'b0;
	end

	// one bus phase, counted on falling edges
	task automatic hold();
		repeat (QUARTER) @(negedge clock);
	endtask

	// one bit; a one releases sda so an acknowledge can be seen at scl high
	task automatic put_bit(input logic b, output logic seen);
		sda_low = ~b;
		hold();
		scl_level = 1'b1;
		hold();
		seen = sda_wire;
		scl_level = 1'b0;
		hold();
	endtask

	// ---------------------------------------------------------------
	// frame: start, address, command, count, data, partial tail, stop
	// ---------------------------------------------------------------
	task automatic frame(input logic [7:0] addr, input logic [7:0] d [8], input int n,
		input int tail, output logic [9:0] acks);
		logic s;
		logic [7:0] b;
		acks = '0;
		sda_low = 1'b1; // start while scl high
		hold();
		scl_level = 1'b0;
		hold();
		for (int k = 0; k < n + 3; k++) begin
			b = (k == 0) ? addr : (k < 3) ? 8'hA5 : d[k-3]; // dummy bytes first
			for (int i = 7; i >= 0; i--) put_bit(b[i], s);
			put_bit(1'b1, s);
			acks[k] = ~s;
		end
		for (int i = 7; i >= 8 - tail; i--) put_bit(d[n][i], s); // msb first, descending order
		sda_low = 1'b1;
		hold();
		scl_level = 1'b1;
		hold();
		sda_low = 1'b0; // stop ends loading
		hold();
	endtask
endmodule

/* File: verif/clock_output_config_bank_bench.sv */
// self-checking bench for the clock output configuration bank
// assumes the package, bank, checker and master model compile first
`timescale 1ns/1ns
`include "clock_cfg_params.svh"

module clock_output_config_bank_bench;
	import clock_cfg_pkg::*;
	localparam int unsigned STRAP_CYCLES = 20;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic scl_level;
	logic sda_low;
	logic sda_out;
	logic sda_oe;
	logic [6:0] straps = 7'h6D;
	logic [5:0] tri_in = 6'h2C; // free bus mid, aux one, tristate zero
	logic [1:0] div = 2'h0;
	logic [12:0] clk_out;
	logic [12:0] clk_oe;
	logic strap_bias_en;
	logic straps_done;
	logic usb_48;
	logic spread_host;
	logic spread_bus;
	logic [6:0] strap_levels;
	level3_t fb_level;
	level3_t aux_level;
	level3_t ot_level;
	logic [7:0] cfg [6];
	logic [7:0] d [8];
	logic [7:0] bad [3] = '{8'hD3, 8'hD0, 8'h52};
	logic [9:0] acks;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	// open drain: either party pulls low, pull-up otherwise
	wire logic sda_pin = ~sda_low & (~sda_oe | sda_out);

	// ---------------------------------------------------------------
	// clock, phase source, timeout
	// ---------------------------------------------------------------
	always #25 clock = ~clock;
	always @(negedge clock) div <= div + 2'h1;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			report_and_stop();
		end
	end

	clock_output_config_bank #(.STRAP_CYCLES(STRAP_CYCLES)) DUT (
		.clock(clock), .rst(rst), .scl_pin(scl_level), .sda_pin(sda_pin),
		.sda_out(sda_out), .sda_oe(sda_oe), .host_pair_disable_strap(straps[6]),
		.usb_freq_strap(straps[5]), .low_emi_strap(straps[4]), .host_speed_strap(straps[3]),
		.host_stop_strap(straps[2]), .bus_stop_strap(straps[1]),
		.cpu_slow_select_strap(straps[0]), .free_bus_select_above_low(tri_in[5]),
		.free_bus_select_above_high(tri_in[4]), .aux_freq_above_low(tri_in[3]),
		.aux_freq_above_high(tri_in[2]), .out_tristate_above_low(tri_in[1]),
		.out_tristate_above_high(tri_in[0]), .clk_phase({13{div[1]}}), .clk_out(clk_out),
		.clk_oe(clk_oe), .strap_bias_en(strap_bias_en), .straps_done(straps_done),
		.strap_levels(strap_levels), .free_bus_select_level(fb_level),
		.aux_freq_level(aux_level), .out_tristate_level(ot_level), .usb_48(usb_48),
		.spread_host(spread_host), .spread_bus(spread_bus));

	i2c_master_model master (.clock(clock), .sda_wire(sda_pin), .scl_level(scl_level),
		.sda_low(sda_low));

	// ---------------------------------------------------------------
	// compare and access tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// which outputs went high over four phase periods
	task automatic check_active(input logic [12:0] exp);
		logic [12:0] seen;
		seen = '0;
		repeat (16) @(posedge clock) #1 seen |= clk_out;
		check({3'h0, seen}, {3'h0, exp});
	endtask

	// slot order: ref, usb, aux, free bus, bus 2..0, mem d..a, fast b, fast a
	function automatic logic [12:0] active_mask();
		return {cfg[5][0], cfg[1][6], cfg[1][7], cfg[2][6], cfg[2][2:0], cfg[3][3:0],
			cfg[1][2], cfg[1][0]};
	endfunction

	task automatic check_state();
		check({13'h0, usb_48, spread_host, spread_bus},
			{13'h0, cfg[0][2], cfg[0][1:0] == 2'h2, cfg[0][1:0] == 2'h2});
		check({3'h0, clk_oe}, {3'h0, {13{cfg[0][1:0] != 2'h3}}});
	endtask

	task automatic send(input logic [7:0] addr, input int n, input int tail,
		input logic [9:0] exp_acks);
		master.frame(addr, d, n, tail, acks);
		check({6'h0, acks}, {6'h0, exp_acks});
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		cfg = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		repeat (10) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		check({14'h0, strap_bias_en, straps_done}, 16'h0002);
		check({3'h0, clk_oe}, 16'h0000);
		repeat (STRAP_CYCLES + 4) @(negedge clock);
		cfg[0][2] = straps[5];
		check({14'h0, strap_bias_en, straps_done}, 16'h0001);
		check({9'h0, strap_levels}, 16'h006D);
		check({10'h0, fb_level, aux_level, ot_level}, 16'h001C);
		check_state();
		check_active(active_mask());
		straps = 7'h16;
		repeat (4) @(negedge clock);
		check({9'h0, strap_levels}, 16'h006D);
		// full frame, pair bits kept equal by the master
		d = '{8'hF8, 8'h4C, 8'h41, 8'h05, 8'h00, 8'hFE, 8'h00, 8'h00};
		send(8'hD2, 6, 0, 10'h1FF);
		cfg = '{8'hF8, 8'h4C, 8'h41, 8'h05, 8'h00, 8'hFE};
		check_state();
		check_active(active_mask());
		// every mode and both usb rates, stopping after the first byte
		for (int m = 0; m < 8; m++) begin
			d[0] = {5'h1, m[2:0]};
			send(8'hD2, 1, 0, 10'h00F);
			cfg[0] = d[0];
			check_state();
		end
		// a half byte after the first is dropped
		d[0] = 8'h04;
		d[1] = 8'h00;
		send(8'hD2, 1, 4, 10'h00F);
		cfg[0] = 8'h04;
		check_state();
		check_active(active_mask());
		// other addresses, the read one among them, change nothing
		d = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int a = 0; a < 3; a++) begin
			send(bad[a], 6, 0, 10'h000);
		end
		check_active(active_mask());
		// a seventh data byte is not acknowledged
		d = '{8'h04, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
		send(8'hD2, 7, 0, 10'h1FF);
		cfg = '{8'h04, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		check_active(active_mask());
		// power-down ignores the bus and keeps the settings
		straps[2] = 1'b0;
		repeat (4) @(negedge clock);
		d = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		send(8'hD2, 6, 0, 10'h000);
		straps[2] = 1'b1;
		repeat (4) @(negedge clock);
		check_active(active_mask());
		report_and_stop();
	end
endmodule

bind clock_output_config_bank clock_cfg_bank_properties #(.STRAP_CYCLES(STRAP_CYCLES)) chk (
	.clock(clock), .rst(rst), .sda_out(sda_out), .sda_oe(sda_oe), .clk_phase(clk_phase),
	.clk_out(clk_out), .clk_oe(clk_oe), .strap_bias_en(strap_bias_en),
	.straps_done(straps_done), .strap_levels(strap_levels), .spread_host(spread_host),
	.spread_bus(spread_bus));
